/* pdt_pkg.sv */
/*
  Package for the power-down activity timers: register indexes, field
  positions, time constants and shared types.
  Assumes a 50 MHz system clock and an 8-bit register port.
*/
package pdt_pkg;

  // Register indexes
  localparam logic [7:0] PDT_TMR0_IDX = 8'h60;
  localparam logic [7:0] PDT_TMR1_IDX = 8'h61;
  localparam logic [7:0] PDT_SYSEN_IDX = 8'h62;
  localparam logic [7:0] PDT_HKEN_IDX = 8'h65;
  localparam logic [7:0] PDT_PINACT_IDX = 8'h67;
  localparam logic [7:0] PDT_TRAPEN_IDX = 8'h69;
  localparam logic [7:0] PDT_SMICTL_IDX = 8'h71;
  localparam logic [7:0] PDT_STAT_IDX = 8'h72;
  localparam logic [7:0] PDT_PSTAT_IDX = 8'h73;
  localparam logic [7:0] PDT_STATE_IDX = 8'h74;
  localparam logic [7:0] PDT_TMR2_IDX = 8'h8D;
  localparam logic [7:0] PDT_RST_VAL = 8'h00;

  // Field positions
  localparam int PDT_SUSP_LSB = 5;
  localparam int PDT_STBY_LSB = 2;
  localparam int PDT_HK_LSB = 4;
  localparam int PDT_PER_LSB = 1;
  localparam int PDT_DOZE_LSB = 5;
  localparam int PDT_ACT_LSB = 1;
  localparam int PDT_HKACT_LSB = 5;
  localparam int PDT_PER_ACT_LSB = 3;

  // Status and SMI control bit positions
  localparam int PDT_B_DOZE = 7;
  localparam int PDT_B_STBY = 6;
  localparam int PDT_B_SUSP = 5;
  localparam int PDT_B_HKTO = 4;
  localparam int PDT_B_HKACT = 3;
  localparam int PDT_B_SYSACT = 2;
  localparam int PDT_B_PERTO = 1;
  localparam int PDT_B_TRAP = 0;

  // Time base: one tick per microsecond
  localparam logic [15:0] PDT_CLK_NS = 16'h0014;
  localparam logic [15:0] PDT_TICK_NS = 16'h03E8;
  localparam int PDT_TICK_DIV = int'(PDT_TICK_NS / PDT_CLK_NS);
  localparam logic [31:0] PDT_US_PER_MS = 32'h0000_03E8;
  localparam logic [31:0] PDT_US_PER_S = 32'h000F_4240;
  localparam logic [31:0] PDT_US_PER_MIN = 32'h0393_8700;

  typedef enum logic [2:0] {
    PDT_ON = 3'b000,
    PDT_DOZE = 3'b001,
    PDT_STBY = 3'b010,
    PDT_SUSP = 3'b011,
    PDT_HK_DOZE = 3'b100,
    PDT_HK_STBY = 3'b101
  } pdt_state_t;

  typedef struct packed {
    logic par;
    logic ser;
    logic keyboard_activity;
    logic fdc;
    logic hard_disk_activity;
  } pdt_per_t;

  typedef struct packed {
    logic drq;
    logic pcim;
    pdt_per_t per;
  } pdt_act_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
  } pdt_io_t;

endpackage

/* pdt_down_timer.sv */
/*
  Reloading down counter for one activity timer, counted in ticks.
  Assumes tick_in is a one-cycle enable on the same clock.
*/
`timescale 1ns/100ps
module pdt_down_timer
  import pdt_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [31:0] period_in,
  output logic expire_out
);

  logic [31:0] cnt_r;
  logic expire_r;

  // Zero period holds the counter cleared
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (period_in == '0) begin
        cnt_r <= '0; // see R25
      end else if (load_in || cnt_r == '0) begin
        cnt_r <= period_in; // see R14
      end else if (run_in && tick_in) begin
        if (cnt_r == 32'h0000_0001) begin
          expire_r <= 1'b1;
          cnt_r <= period_in;
        end else begin
          cnt_r <= cnt_r - 32'h0000_0001;
        end
      end
    end
  end

  assign expire_out = expire_r;

  hold_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R25
    (period_in == '0) |=> (cnt_r == '0))
    else $error("timer not held cleared");

  stall_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R15
    (!run_in && !load_in && cnt_r != '0 && $stable(period_in)) |=> $stable(cnt_r))
    else $error("timer moved while stopped");

endmodule // pdt_down_timer

/* pdt_power_timers.sv */
/*
  Power-down activity timers: activity decode, suspend, standby, doze,
  house-keeping and peripheral timers, power state and I/O trapping.
  Assumes decoded I/O cycles on the system clock and an 8-bit register
  port with read data one cycle after the read strobe.
*/
// The implementer's own choice: the address-and-strobe port.
// Functional notes
// R1 - Peripheral activity never restarts peripheral timer
// R2 - Peripheral expiry interrupts only for idle peripherals
// R3 - Trap accesses to powered-down peripherals, hold
// R4 - Transparent mode: auto doze/standby, never suspend
// R5 - No house-keeping entry from suspend
// R6 - DMA activity on rising hold request
// R7 - Bus master activity on falling request line
// R8 - Parallel port address ranges flag activity
// R9 - Serial port address ranges flag activity
// R10 - Keyboard addresses flag activity
// R11 - Floppy addresses flag activity
// R12 - Hard disk addresses or IDE mastering
// R13 - Suspend field selects four to 64 minutes
// R14 - System activity restarts power-down timers
// R15 - Suspend counts while enabled, flag clear
// R16 - Standby field selects two to 16 minutes
// R17 - Standby counts while enabled, flag clear
// R18 - House-keeping field selects excursion length
// R19 - House-keeping counts only in excursion, restarts
// R20 - System activity in excursion acts as doze
// R21 - Peripheral field selects 8 to 512 seconds
// R22 - Doze field code one is 50 ms
// R23 - Doze counts while enabled; longer codes
// R24 - Doze control bit picks interrupt or auto
// R25 - Prescaled tick; zero field clears timer
`timescale 1ns/100ps
module pdt_power_timers
  import pdt_pkg::*;
#(
  parameter int TICK_DIV = PDT_TICK_DIV
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire pdt_io_t io_cyc_in,
  input wire logic hold_req_in,
  input wire logic [2:0] bus_master_request_lines_n_in,
  input wire logic ide_master_in,
  output logic smi_out,
  output logic io_hold_out,
  output logic [2:0] power_state_out,
  output logic cpu_clk_slow_out
);

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic pdt_per_t decode_io(input logic [15:0] a);
    pdt_per_t p;
    p.par = in_rng(a, 16'h0378, 16'h037F) || in_rng(a, 16'h0278, 16'h027F) ||
            in_rng(a, 16'h03BC, 16'h03BF); // see R8
    p.ser = in_rng(a, 16'h03F8, 16'h03FF) || in_rng(a, 16'h02F8, 16'h02FF) ||
            in_rng(a, 16'h03E8, 16'h03EF) || in_rng(a, 16'h02E8, 16'h02EF); // see R9
    p.keyboard_activity = (a == 16'h0060) || (a == 16'h0062) || (a == 16'h0064) ||
            (a == 16'h0066); // see R10
    p.fdc = (a == 16'h03F2) || (a == 16'h03F4) || (a == 16'h03F5) ||
            (a == 16'h03F7); // see R11
    p.hard_disk_activity = in_rng(a, 16'h0170, 16'h0177) || (a == 16'h0376) ||
            in_rng(a, 16'h01F0, 16'h01F7) || (a == 16'h03F6); // see R12
    return p;
  endfunction

  function automatic logic [31:0] susp_ticks(input logic [2:0] c);
    logic [7:0] m;
    unique case (c)
      3'h1: m = 8'h04;
      3'h2: m = 8'h08;
      3'h3: m = 8'h0C;
      3'h4: m = 8'h10;
      3'h5: m = 8'h20;
      3'h6: m = 8'h30;
      3'h7: m = 8'h40;
      default: m = 8'h00;
    endcase
    return 32'(m * PDT_US_PER_MIN); // see R13
  endfunction

  function automatic logic [31:0] stby_ticks(input logic [2:0] c);
    logic [7:0] m;
    unique case (c)
      3'h2: m = 8'h02;
      3'h3: m = 8'h04;
      3'h4: m = 8'h06;
      3'h5: m = 8'h08;
      3'h6: m = 8'h0C;
      3'h7: m = 8'h10;
      default: m = 8'h00;
    endcase
    return 32'(m * PDT_US_PER_MIN); // see R16
  endfunction

  function automatic logic [31:0] hk_ticks(input logic [2:0] c);
    logic [31:0] t;
    unique case (c)
      3'h1: t = 32'h0000_0040;
      3'h2: t = 32'h0000_0080;
      3'h3: t = 32'h0000_0100;
      3'h5: t = 32'(32'h4 * PDT_US_PER_MS);
      3'h6: t = 32'(32'h10 * PDT_US_PER_MS);
      3'h7: t = 32'(32'h20 * PDT_US_PER_MS);
      default: t = 32'h0000_0000;
    endcase
    return t; // see R18
  endfunction

  function automatic logic [31:0] per_ticks(input logic [2:0] c);
    logic [31:0] t;
    t = (c == 3'h0) ? 32'h0 : 32'(PDT_US_PER_S << (32'(c) + 32'h2));
    return t; // see R21
  endfunction

  function automatic logic [31:0] doze_ticks(input logic [2:0] c);
    logic [31:0] t;
    unique case (c)
      3'h1: t = 32'(32'h32 * PDT_US_PER_MS); // see R22
      3'h2: t = 32'(32'h64 * PDT_US_PER_MS);
      3'h3: t = 32'(32'h1F4 * PDT_US_PER_MS);
      3'h5: t = 32'(32'h4 * PDT_US_PER_S);
      3'h6: t = 32'(32'h8 * PDT_US_PER_S);
      3'h7: t = 32'(32'h10 * PDT_US_PER_S);
      default: t = 32'h0000_0000;
    endcase
    return t; // see R23
  endfunction

  logic [7:0] tmr0_r, tmr1_r, tmr2_r, sysen_r, hken_r, pinact_r;
  logic [7:0] trapen_r, smictl_r, stat_r, pstat_r, rdata_r;
  pdt_state_t state_r, state_nxt;
  logic smi_r, hold_r, slow_r;
  logic [2:0] hold_s1_r, hold_s2_r, hold_d_r;
  logic [2:0] bm_s1_r, bm_s2_r, bm_d_r;
  pdt_per_t seen_r;
  logic [15:0] div_r;
  logic tick_r;

  // Pin synchronisers; stage one feeds stage two only
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_s1_r <= '0;
      hold_s2_r <= '0;
      hold_d_r <= '0;
      bm_s1_r <= 3'h7;
      bm_s2_r <= 3'h7;
      bm_d_r <= 3'h7;
    end else begin
      hold_s1_r <= {2'h0, hold_req_in};
      hold_s2_r <= hold_s1_r;
      hold_d_r <= hold_s2_r;
      bm_s1_r <= bus_master_request_lines_n_in;
      bm_s2_r <= bm_s1_r;
      bm_d_r <= bm_s2_r;
    end
  end

  pdt_act_t act;
  pdt_per_t io_hit;
  logic io_act, sys_act, hk_act, in_pd, in_hk, per_exp;
  logic doze_exp, stby_exp, susp_exp, hk_exp;
  logic [7:0] stat_set, pinact_now;

  always_comb begin
    io_act = io_cyc_in.rd || io_cyc_in.wr;
    io_hit = io_act ? decode_io(io_cyc_in.addr) : '0;
    act.drq = hold_s2_r[0] && !hold_d_r[0]; // see R6
    act.pcim = |(bm_d_r & ~bm_s2_r); // see R7
    act.per = io_hit;
    act.per.hard_disk_activity = io_hit.hard_disk_activity || ide_master_in; // see R12
  end

  assign sys_act = |(act & sysen_r[7:PDT_ACT_LSB]); // see R14
  assign in_pd = (state_r == PDT_DOZE) || (state_r == PDT_STBY);
  assign in_hk = (state_r == PDT_HK_DOZE) || (state_r == PDT_HK_STBY);
  // Excursions only from doze or standby, never suspend
  assign hk_act = (in_pd || in_hk) && // see R5
    |({act.drq, act.pcim, act.per.keyboard_activity} & hken_r[7:PDT_HKACT_LSB]);

  // Prescaled microsecond tick
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 16'(TICK_DIV - 1)); // see R25
      div_r <= (div_r == 16'(TICK_DIV - 1)) ? '0 : div_r + 16'h0001;
    end
  end

  pdt_down_timer u_susp (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_r),
    .run_in(!stat_r[PDT_B_SUSP]), .load_in(sys_act), // see R15
    .period_in(susp_ticks(tmr0_r[PDT_SUSP_LSB +: 3])), .expire_out(susp_exp));
  pdt_down_timer u_stby (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_r),
    .run_in(!stat_r[PDT_B_STBY]), .load_in(sys_act), // see R17
    .period_in(stby_ticks(tmr0_r[PDT_STBY_LSB +: 3])), .expire_out(stby_exp));
  pdt_down_timer u_doze (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_r),
    .run_in(!stat_r[PDT_B_DOZE]), .load_in(sys_act), // see R23
    .period_in(doze_ticks(tmr2_r[PDT_DOZE_LSB +: 3])), .expire_out(doze_exp));
  pdt_down_timer u_hk (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_r),
    .run_in(in_hk), .load_in(hk_act || !in_hk), // see R19
    .period_in(hk_ticks(tmr1_r[PDT_HK_LSB +: 3])), .expire_out(hk_exp));
  // Peripheral timer is never reloaded by activity
  pdt_down_timer u_per (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_r),
    .run_in(1'b1), .load_in(1'b0), // see R1
    .period_in(per_ticks(tmr1_r[PDT_PER_LSB +: 3])), .expire_out(per_exp));

  // Peripherals seen during the current period
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_r <= '0;
    end else begin
      seen_r <= per_exp ? act.per : (seen_r | act.per);
    end
  end

  assign pinact_now = {pinact_r[7:PDT_PER_ACT_LSB] & ~(seen_r | act.per),
                       {PDT_PER_ACT_LSB{1'b0}}};

  always_comb begin
    stat_set = '0;
    stat_set[PDT_B_DOZE] = doze_exp;
    stat_set[PDT_B_STBY] = stby_exp;
    stat_set[PDT_B_SUSP] = susp_exp;
    stat_set[PDT_B_HKTO] = hk_exp && in_hk && smictl_r[PDT_B_HKTO];
    stat_set[PDT_B_HKACT] = hk_act && smictl_r[PDT_B_HKACT];
    stat_set[PDT_B_SYSACT] = sys_act && (in_pd || in_hk) && smictl_r[PDT_B_SYSACT];
    stat_set[PDT_B_PERTO] = per_exp && (|pinact_now); // see R2
    stat_set[PDT_B_TRAP] = |(io_hit & trapen_r[7:PDT_PER_ACT_LSB]); // see R3
  end

  // Power state transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PDT_ON: begin
        if (stby_exp && !smictl_r[PDT_B_STBY]) begin
          state_nxt = PDT_STBY; // see R4
        end else if (doze_exp && !smictl_r[PDT_B_DOZE]) begin
          state_nxt = PDT_DOZE; // see R24
        end
      end
      PDT_DOZE, PDT_STBY: begin
        if (sys_act && !smictl_r[PDT_B_SYSACT]) begin
          state_nxt = PDT_ON; // see R4
        end else if (hk_act && !smictl_r[PDT_B_HKACT] &&
                     hk_ticks(tmr1_r[PDT_HK_LSB +: 3]) != '0) begin
          state_nxt = (state_r == PDT_DOZE) ? PDT_HK_DOZE : PDT_HK_STBY;
        end else if (state_r == PDT_DOZE && stby_exp && !smictl_r[PDT_B_STBY]) begin
          state_nxt = PDT_STBY;
        end
      end
      PDT_HK_DOZE, PDT_HK_STBY: begin
        if (sys_act && !smictl_r[PDT_B_SYSACT]) begin
          state_nxt = PDT_ON; // see R20
        end else if (hk_exp && !smictl_r[PDT_B_HKTO]) begin
          state_nxt = (state_r == PDT_HK_DOZE) ? PDT_DOZE : PDT_STBY;
        end
      end
      PDT_SUSP: state_nxt = PDT_SUSP;
      default: state_nxt = PDT_ON;
    endcase
    // Only software moves the state into suspend
    if (reg_wr_in && reg_addr_in == PDT_STATE_IDX) begin
      state_nxt = pdt_state_t'(reg_wdata_in[2:0]); // see R4
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= PDT_ON;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Software-written control registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr0_r <= PDT_RST_VAL;
      tmr1_r <= PDT_RST_VAL;
      tmr2_r <= PDT_RST_VAL;
      sysen_r <= PDT_RST_VAL;
      hken_r <= PDT_RST_VAL;
      pinact_r <= PDT_RST_VAL;
      trapen_r <= PDT_RST_VAL;
      smictl_r <= PDT_RST_VAL;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        PDT_TMR0_IDX: tmr0_r <= reg_wdata_in & 8'hFC;
        PDT_TMR1_IDX: tmr1_r <= reg_wdata_in & 8'h7E;
        PDT_TMR2_IDX: tmr2_r <= reg_wdata_in & 8'hE0;
        PDT_SYSEN_IDX: sysen_r <= reg_wdata_in & 8'hFE;
        PDT_HKEN_IDX: hken_r <= reg_wdata_in & 8'hE0;
        PDT_PINACT_IDX: pinact_r <= reg_wdata_in & 8'hF8;
        PDT_TRAPEN_IDX: trapen_r <= reg_wdata_in & 8'hF8;
        PDT_SMICTL_IDX: smictl_r <= reg_wdata_in & 8'hFC;
        default: ;
      endcase
    end
  end

  // Sticky status; a set wins over a write-one clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_r <= PDT_RST_VAL;
      pstat_r <= PDT_RST_VAL;
    end else begin
      stat_r <= (stat_r & ~((reg_wr_in && reg_addr_in == PDT_STAT_IDX) ?
                reg_wdata_in : 8'h00)) | stat_set;
      pstat_r <= (pstat_r & ~((reg_wr_in && reg_addr_in == PDT_PSTAT_IDX) ?
                 reg_wdata_in : 8'h00)) | (per_exp ? pinact_now : 8'h00);
    end
  end

  // Outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      smi_r <= 1'b0;
      hold_r <= 1'b0;
      slow_r <= 1'b0;
    end else begin
      smi_r <= |((stat_set | stat_r) & (smictl_r | 8'h0F)); // see R24
      hold_r <= stat_set[PDT_B_TRAP] || (hold_r && stat_r[PDT_B_TRAP]); // see R3
      slow_r <= (state_nxt == PDT_DOZE) || (state_nxt == PDT_STBY); // see R4
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= PDT_RST_VAL;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        PDT_TMR0_IDX: rdata_r <= tmr0_r;
        PDT_TMR1_IDX: rdata_r <= tmr1_r;
        PDT_TMR2_IDX: rdata_r <= tmr2_r;
        PDT_SYSEN_IDX: rdata_r <= sysen_r;
        PDT_HKEN_IDX: rdata_r <= hken_r;
        PDT_PINACT_IDX: rdata_r <= pinact_r;
        PDT_TRAPEN_IDX: rdata_r <= trapen_r;
        PDT_SMICTL_IDX: rdata_r <= smictl_r;
        PDT_STAT_IDX: rdata_r <= stat_r;
        PDT_PSTAT_IDX: rdata_r <= pstat_r;
        PDT_STATE_IDX: rdata_r <= {5'h00, state_r};
        default: rdata_r <= PDT_RST_VAL;
      endcase
    end else begin
      rdata_r <= PDT_RST_VAL;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign smi_out = smi_r;
  assign io_hold_out = hold_r;
  assign power_state_out = state_r;
  assign cpu_clk_slow_out = slow_r;

  sequence hk_entry_s;
    in_pd && hk_act && !smictl_r[PDT_B_HKACT] && !sys_act && !reg_wr_in &&
    hk_ticks(tmr1_r[PDT_HK_LSB +: 3]) != '0;
  endsequence

  no_hk_susp_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R5
    (state_r == PDT_SUSP && !reg_wr_in) |=> (state_r == PDT_SUSP))
    else $error("left suspend without software");
  hk_enter_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R19
    hk_entry_s |=> in_hk)
    else $error("house-keeping excursion not entered");
  auto_doze_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R24
    (state_r == PDT_ON && doze_exp && !stby_exp && !smictl_r[PDT_B_DOZE] && !reg_wr_in)
    |=> (state_r == PDT_DOZE) && cpu_clk_slow_out)
    else $error("auto doze missing");
  quiet_doze_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R4
    (doze_exp && !smictl_r[PDT_B_DOZE] && (stat_r | stat_set) == 8'(1 << PDT_B_DOZE))
    |=> !smi_out)
    else $error("interrupt in transparent doze");
  hk_wake_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R20
    (in_hk && sys_act && !smictl_r[PDT_B_SYSACT] && !reg_wr_in) |=> (state_r == PDT_ON))
    else $error("system activity did not wake");
  dma_edge_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R6
    act.drq |-> $past(hold_req_in, 2) && (!$past(hold_req_in, 3) || $past(rst_in, 3)))
    else $error("dma activity without rising edge");
  per_smi_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R2
    (per_exp && pinact_now == '0) |=> !stat_r[PDT_B_PERTO] || $past(stat_r[PDT_B_PERTO]))
    else $error("peripheral interrupt with no idle peripheral");
  trap_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R3
    stat_set[PDT_B_TRAP] |=> io_hold_out && smi_out)
    else $error("trapped access not held");
  kbd_dec_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see R10
    (io_act && io_cyc_in.addr == 16'h0064) |-> act.per.keyboard_activity)
    else $error("keyboard access missed");

endmodule // pdt_power_timers

/* pdt_host_model.sv */
/*
  I/O-bus model of the host side: decoded I/O cycles and request pins.
  Assumes the power-down timers sample everything on mclk_in.
*/
`timescale 1ns/100ps
module pdt_host_model
  import pdt_pkg::*;
(
  input wire logic mclk_in,
  output pdt_io_t io_cyc_out,
  output logic hold_req_out,
  output logic [2:0] bm_req_n_out,
  output logic ide_master_out
);
  initial begin
    io_cyc_out = '0;
    hold_req_out = 1'b0;
    bm_req_n_out = 3'h7;
    ide_master_out = 1'b0;
  end

  // One-cycle access; released address shows its inverse
  task automatic access(input logic [15:0] a, input logic w);
    @(posedge mclk_in);
    io_cyc_out <= '{addr: a, rd: !w, wr: w};
    @(posedge mclk_in);
    io_cyc_out <= '{addr: ~a, rd: 1'b0, wr: 1'b0};
  endtask

  task automatic pins(input logic h, input logic [2:0] bm, input logic ide);
    @(posedge mclk_in);
    hold_req_out <= h;
    bm_req_n_out <= bm;
    ide_master_out <= ide;
    @(posedge mclk_in);
    ide_master_out <= 1'b0;
  endtask
endmodule // pdt_host_model

/* power_down_activity_timers_tb.sv */
/*
  Self-checking bench for the power-down activity timers.
  Assumes TICK_DIV of 1, so timer ticks are clock cycles.
*/
`timescale 1ns/100ps
module power_down_activity_timers_tb;
  import pdt_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  pdt_io_t io_cyc;
  logic hold_req, ide_master, smi_out, io_hold_out, cpu_clk_slow_out;
  logic [2:0] bm_n, power_state_out;
  logic [17:0] exp_q[$];
  logic [17:0] ent;
  logic rd_q = 1'b0;
  logic [15:0] seed = 16'hB0C9;
  logic [23:0] tab[23] = '{24'h037880, 24'h037F80, 24'h027880, 24'h03BF80,
    24'h03F840, 24'h02EF40, 24'h03E840, 24'h02F840, 24'h006020, 24'h006620,
    24'h03F210, 24'h03F510, 24'h03F710, 24'h017008, 24'h037608, 24'h01F708,
    24'h03F608, 24'h037700, 24'h03C000, 24'h006100, 24'h03F300, 24'h017800,
    24'h02E700};
  logic hit;
  logic slow_e;
  int num_errors = 0;
  int checks_done = 0;

  pdt_power_timers #(.TICK_DIV(1)) i_pdt_power_timers (.mclk_in(mclk_in),
    .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .io_cyc_in(io_cyc), .hold_req_in(hold_req),
    .bus_master_request_lines_n_in(bm_n), .ide_master_in(ide_master),
    .smi_out(smi_out), .io_hold_out(io_hold_out),
    .power_state_out(power_state_out), .cpu_clk_slow_out(cpu_clk_slow_out));

  pdt_host_model i_pdt_host_model (.mclk_in(mclk_in), .io_cyc_out(io_cyc),
    .hold_req_out(hold_req), .bm_req_n_out(bm_n), .ide_master_out(ide_master));

  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction

  task automatic check(input logic [7:0] a, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL reg %h expected %h seen %h", a, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Expectation is {smi, hold, read data}
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    exp_q.push_back({a, e});
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (rd_q && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      check(ent[17:10], {smi_out, io_hold_out, reg_rdata_out}, ent[9:0]);
      if (ent[17:10] == PDT_STATE_IDX) begin
        slow_e = (ent[2:0] == PDT_DOZE) || (ent[2:0] == PDT_STBY);
        check(ent[17:10], {1'b0, cpu_clk_slow_out, 5'h00, power_state_out}, {1'b0, slow_e, 5'h00, ent[2:0]});
      end
    end
    rd_q <= reg_rd_in;
  end

  initial begin
    idle(95000);
    num_errors++;
    give_verdict();
  end

  initial begin
    idle(16);
    rst_in <= 1'b0;
    rd(8'h60, 10'h000);
    rd(8'h61, 10'h000);
    rd(8'h8D, 10'h000);
    rd(8'h50, 10'h000);
    seed = xs();
    wr(8'h61, seed[7:0]);
    rd(8'h61, {2'b00, seed[7:0] & 8'h7E});
    wr(8'h60, 8'hFF);
    rd(8'h60, 10'h0FC);
    wr(8'h8D, 8'hFF);
    rd(8'h8D, 10'h0E0);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h00);
    wr(8'h8D, 8'h00);
    // Each class traps with its own enable bit; other addresses never trap with all bits set
    foreach (tab[i]) begin
      hit = (tab[i][7:0] != 8'h00);
      wr(8'h69, hit ? tab[i][7:0] : 8'hF8);
      i_pdt_host_model.access(tab[i][23:8], xs() & 16'h0001);
      idle(2);
      rd(8'h72, {hit, hit, 7'h00, hit});
      if (hit) begin
        wr(8'h72, 8'h01);
        rd(8'h72, 10'h000);
      end
    end
    wr(8'h69, 8'h00);
    wr(8'h61, 8'h10);
    wr(8'h65, 8'h20);
    wr(8'h74, 8'h01);
    i_pdt_host_model.access(16'h0060, 1'b0);
    idle(40);
    rd(8'h74, 10'h004);
    i_pdt_host_model.access(16'h0064, 1'b1);
    idle(40);
    rd(8'h74, 10'h004);
    idle(40);
    rd(8'h74, 10'h001);
    wr(8'h74, 8'h03);
    i_pdt_host_model.access(16'h0060, 1'b0);
    idle(5);
    rd(8'h74, 10'h003);
    wr(8'h62, 8'hC0);
    wr(8'h74, 8'h01);
    i_pdt_host_model.pins(1'b1, 3'h7, 1'b0);
    idle(8);
    rd(8'h74, 10'h000);
    wr(8'h74, 8'h01);
    i_pdt_host_model.pins(1'b0, 3'h7, 1'b0);
    idle(8);
    rd(8'h74, 10'h001);
    wr(8'h74, 8'h04);
    i_pdt_host_model.pins(1'b1, 3'h7, 1'b0);
    idle(8);
    rd(8'h74, 10'h000);
    wr(8'h74, 8'h01);
    i_pdt_host_model.pins(1'b1, 3'h5, 1'b0);
    idle(8);
    rd(8'h74, 10'h000);
    wr(8'h62, 8'h02);
    wr(8'h74, 8'h02);
    i_pdt_host_model.pins(1'b1, 3'h5, 1'b1);
    idle(8);
    rd(8'h74, 10'h000);
    wr(8'h61, 8'h00);
    wr(8'h65, 8'h00);
    wr(8'h62, 8'h08);
    wr(8'h8D, 8'h20);
    idle(30000);
    i_pdt_host_model.access(16'h0064, 1'b0);
    idle(30000);
    rd(8'h74, 10'h000);
    idle(21000);
    rd(8'h74, 10'h001);
    wr(8'h71, 8'h04);
    i_pdt_host_model.access(16'h0064, 1'b1);
    idle(4);
    rd(8'h74, 10'h201);
    rd(8'h72, 10'h284);
    idle(4);
    give_verdict();
  end
endmodule // power_down_activity_timers_tb
